// File: psw_buf.sv
// two-entry buffer for power control words
`timescale 1ns/1ps
`default_nettype none
`include "psw_regs.svh"
module psw_buf (
  // clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       rst_n_in,
  input  wire logic                       clr_in,
  // fill side
  input  wire logic                       in_valid_in,
  input  wire logic [`PSW_FRAME_BITS-1:0] in_data_in,
  output logic                            in_ready_out,
  // drain side
  output logic                            out_valid_out,
  output logic [`PSW_FRAME_BITS-1:0]      out_data_out,
  input  wire logic                       out_ready_in
);
  logic [`PSW_FRAME_BITS-1:0] mem_ff [2];
  logic                       wr_ptr_ff;
  logic                       rd_ptr_ff;
  logic [1:0]                 count_ff;
  wire                        do_wr = in_valid_in & in_ready_out;
  wire                        do_rd = out_valid_out & out_ready_in;

  // honest full and empty from the occupancy count
  assign in_ready_out  = (count_ff != 2'h2);
  assign out_valid_out = (count_ff != 2'h0);
  assign out_data_out  = mem_ff[rd_ptr_ff];

  // clear only on a non-suspend reset so contents survive suspend
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff  <= 2'h0;
    end else if (clr_in) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff  <= 2'h0;
    end else begin
      if (do_wr) wr_ptr_ff <= ~wr_ptr_ff;
      if (do_rd) rd_ptr_ff <= ~rd_ptr_ff;
      count_ff <= count_ff + {1'b0, do_wr} - {1'b0, do_rd};
    end
  end

  // storage entries
  always_ff @(posedge clk_in) begin
    if (do_wr) mem_ff[wr_ptr_ff] <= in_data_in;
  end
endmodule
`default_nettype wire

// File: psw_chk.sv
// assertions on the power switch serial port pins
`timescale 1ns/1ps
`default_nettype none
module psw_chk (
  // clock, resets and inputs
  input wire logic clk_in, rst_n_in, bus_reset_n_in, suspend_in,
  input wire logic clock_direction_select_in, strobe_in,
  // outputs
  input wire logic busy_out, sclk_out, sclk_oe_out, data_out,
  input wire logic data_oe_out, strobe_out, strobe_oe_out,
  input wire logic eeprom_on_alt_pins_out
);
  // one domain, so shared clocking and disable
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_sclk_dir: assert property (
    !clock_direction_select_in && !$past(clock_direction_select_in)
    |-> !sclk_oe_out) else $error("clock driven while input");
  a_sclk_div: assert property (
    bus_reset_n_in && sclk_oe_out && $changed(sclk_out) |=>
    (!$changed(sclk_out) || !sclk_oe_out)[*8] ##10
    ($changed(sclk_out) || !sclk_oe_out)) else $error("bad divide");
  a_pins_float: assert property (
    !bus_reset_n_in && !$past(bus_reset_n_in) |->
    !data_oe_out && !strobe_oe_out && !sclk_oe_out) else $error("pins on");
  a_reset_clears: assert property (
    !bus_reset_n_in && !suspend_in && !$past(bus_reset_n_in)
    |=> !busy_out && !strobe_out) else $error("state not cleared");
  a_suspend_keeps: assert property (
    !bus_reset_n_in && suspend_in && !$past(bus_reset_n_in) &&
    $past(suspend_in) |=> $stable(busy_out) && $stable(data_out))
    else $error("state lost in suspend");
  a_strobe_hold: assert property (
    strobe_out && $past(strobe_out) |-> $stable(data_out))
    else $error("data moved under strobe");
  a_strobe_len: assert property (
    bus_reset_n_in && sclk_oe_out && $rose(strobe_out) |->
    strobe_out[*8] ##29 (!strobe_out || !sclk_oe_out))
    else $error("strobe length");
  a_data_rise: assert property (
    bus_reset_n_in && sclk_oe_out && $rose(sclk_out) |->
    $stable(data_out)[*4]) else $error("data moved at rise");
  a_strap_read: assert property (
    $rose(bus_reset_n_in) && !$past(suspend_in) |->
    ##3 eeprom_on_alt_pins_out != $past(strobe_in, 3))
    else $error("strap misread");
endmodule
bind psw_port psw_chk psw_chk_i (.*);
`default_nettype wire

// File: psw_pkg.sv
// types for the power switch serial port
package psw_pkg;
  typedef enum logic [3:0] {
    PSW_IDLE  = 4'b0001,
    PSW_SHIFT = 4'b0010,
    PSW_STROBE = 4'b0100,
    PSW_HOLD  = 4'b1000
  } psw_state_t;
endpackage

// File: psw_port.sv
// three-line power switch serial port with reset and strap handling
`timescale 1ns/1ps
`default_nettype none
`include "psw_regs.svh"
module psw_port (
  // clock and resets
  input  wire logic                       clk_in,
  input  wire logic                       rst_n_in,
  input  wire logic                       bus_reset_n_in,
  input  wire logic                       suspend_in,
  // control
  input  wire logic                       clock_direction_select_in,
  // power control words
  input  wire logic                       word_valid_in,
  input  wire logic [`PSW_FRAME_BITS-1:0] word_data_in,
  output logic                            word_ready_out,
  output logic                            busy_out,
  // switch pins
  input  wire logic                       sclk_in,
  output logic                            sclk_out,
  output logic                            sclk_oe_out,
  output logic                            data_out,
  output logic                            data_oe_out,
  input  wire logic                       strobe_in,
  output logic                            strobe_out,
  output logic                            strobe_oe_out,
  // eeprom pin mapping
  output logic                            eeprom_on_alt_pins_out,
  output logic                            eeprom_clock_pin_sel_out,
  output logic                            eeprom_data_pin_sel_out
);
  logic                       rst_s1_ff;
  logic                       rst_s2_ff;
  logic                       bus_rst_ff;
  logic                       susp_ff;
  logic                       strap_ff;
  logic [`PSW_CNT_W-1:0]      div_ff;
  logic                       gen_clk_ff;
  logic                       sclk_s1_ff;
  logic                       sclk_s2_ff;
  logic                       sclk_d_ff;
  psw_pkg::psw_state_t        state_ff;
  psw_pkg::psw_state_t        nxt_state;
  logic [`PSW_FRAME_BITS-1:0] shift_ff;
  logic [`PSW_BIT_W-1:0]      bits_ff;
  logic                       data_ff;
  logic                       strobe_ff;
  logic                       buf_valid;
  logic [`PSW_FRAME_BITS-1:0] buf_data;
  wire                        pop;
  wire                        gen_rise;
  wire                        gen_fall;
  wire                        ext_rise;
  wire                        ext_fall;
  wire                        s_rise;
  wire                        s_fall;
  wire                        clr;
  wire                        floating;

  // reset release through two flops
  // both flops see the raw reset; the second releases one cycle after the first
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end

  // bus reset and suspend sampled on the rising bus clock
  // both are plain levels, so one flop each is enough here
  always_ff @(posedge clk_in or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      bus_rst_ff <= 1'b1;
      susp_ff    <= 1'b0;
    end else begin
      bus_rst_ff <= ~bus_reset_n_in;
      susp_ff    <= suspend_in;
    end
  end

  // clear everything only when suspend is not held
  assign clr      = bus_rst_ff & ~susp_ff;
  assign floating = bus_rst_ff;
  // a suspended reset floats the pins and freezes the sequencer and strap, but the divider keeps counting

  // strap read while the bus reset floats the strobe pin, so the pin
  // shows only its board pull; once the port drives it the level is
  // our own and says nothing about the board; a suspended reset keeps
  // the last reading, and the reading at release is the default map
  always_ff @(posedge clk_in or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      strap_ff <= 1'b0;
    end else if (clr) begin
      strap_ff <= ~strobe_in;  // pulled low
    end
  end

  // all three follow the one strap; kept apart for the pin muxes
  assign eeprom_on_alt_pins_out   = strap_ff;
  assign eeprom_clock_pin_sel_out = strap_ff;        // pin four as scl
  assign eeprom_data_pin_sel_out  = strap_ff;        // pin one as sda

  // divide by 36: half period of 18 cycles, 50 MHz gives ~1.39 MHz
  // a suspended reset does not stop it, so the clock resumes mid-phase
  // while the frame itself stays frozen until release
  always_ff @(posedge clk_in or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      div_ff     <= 5'h00;
      gen_clk_ff <= 1'b0;
    end else if (clr) begin
      div_ff     <= 5'h00;
      gen_clk_ff <= 1'b0;
    end else if (div_ff == 5'(`PSW_HALF_DIV - 1)) begin
      div_ff     <= 5'h00;
      gen_clk_ff <= ~gen_clk_ff;
    end else begin
      div_ff <= div_ff + 5'h01;
    end
  end

  // external shift clock synchronised; first flop feeds only the second
  // edges are acted on three bus cycles late, so the outside clock
  // must stay far below a sixth of the bus clock
  always_ff @(posedge clk_in or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      sclk_d_ff  <= 1'b0;
    end else begin
      sclk_s1_ff <= sclk_in;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_d_ff  <= sclk_s2_ff;
    end
  end

  // edge selection by clock direction
  // only one source is honoured at a time; flipping the direction
  // in mid-frame can cost or repeat a bit
  assign gen_rise = (div_ff == 5'(`PSW_HALF_DIV - 1)) & ~gen_clk_ff;
  assign gen_fall = (div_ff == 5'(`PSW_HALF_DIV - 1)) & gen_clk_ff;
  assign ext_rise = sclk_s2_ff & ~sclk_d_ff;
  assign ext_fall = ~sclk_s2_ff & sclk_d_ff;
  assign s_rise   = clock_direction_select_in ? gen_rise : ext_rise;
  assign s_fall   = clock_direction_select_in ? gen_fall : ext_fall;

  // words waiting for the switch; a slow link stalls the source
  // cleared with the rest on a plain bus reset, kept under suspend
  psw_buf u_buf (
    .clk_in        (clk_in),
    .rst_n_in      (rst_s2_ff),
    .clr_in        (clr),
    .in_valid_in   (word_valid_in),
    .in_data_in    (word_data_in),
    .in_ready_out  (word_ready_out),
    .out_valid_out (buf_valid),
    .out_data_out  (buf_data),
    .out_ready_in  (pop)
  );

  // a word leaves only on a falling edge, so its first bit gets a full
  // half period of setup before the switch samples it on the divided clock,
  // and three bus cycles less on an outside clock
  assign pop = (state_ff == psw_pkg::PSW_IDLE) & buf_valid & s_fall & ~floating;

  // frame sequencer: data changes on falling edges only
  // strobe and hold each last one shift period, which spaces frames;
  // an illegal code falls to the default branch and heads home
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      psw_pkg::PSW_IDLE:   if (pop) nxt_state = psw_pkg::PSW_SHIFT;
      psw_pkg::PSW_SHIFT:  if (s_fall && bits_ff == 4'h0)
                             nxt_state = psw_pkg::PSW_STROBE;
      psw_pkg::PSW_STROBE: if (s_fall) nxt_state = psw_pkg::PSW_HOLD;
      psw_pkg::PSW_HOLD:   if (s_fall) nxt_state = psw_pkg::PSW_IDLE;
      default:             nxt_state = psw_pkg::PSW_IDLE;
    endcase
  end

  // state, shifter and pin registers
  // the clear path repeats the reset values so a bus reset alone
  // returns the sequencer to its start
  always_ff @(posedge clk_in or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      state_ff  <= psw_pkg::PSW_IDLE;
      shift_ff  <= 8'h00;
      bits_ff   <= 4'h0;
      data_ff   <= 1'b0;
      strobe_ff <= 1'b0;
    end else if (clr) begin
      state_ff  <= psw_pkg::PSW_IDLE;
      shift_ff  <= 8'h00;
      bits_ff   <= 4'h0;
      data_ff   <= 1'b0;
      strobe_ff <= 1'b0;
    end else if (!bus_rst_ff) begin
      state_ff <= nxt_state;
      if (pop) begin
        data_ff  <= buf_data[`PSW_FRAME_BITS-1];     // msb first
        shift_ff <= {buf_data[`PSW_FRAME_BITS-2:0], 1'b0};
        bits_ff  <= 4'(`PSW_FRAME_BITS - 1);
      end else if (state_ff == psw_pkg::PSW_SHIFT && s_fall &&
                   bits_ff != 4'h0) begin
        data_ff  <= shift_ff[`PSW_FRAME_BITS-1];
        shift_ff <= {shift_ff[`PSW_FRAME_BITS-2:0], 1'b0};
        bits_ff  <= bits_ff - 4'h1;
      end
      // strobe after last bit sampled, data frozen meanwhile
      strobe_ff <= (nxt_state == psw_pkg::PSW_STROBE);
    end
  end

  // outputs float while the bus reset is held
  // the divided clock runs free; only its enable decides who drives
  assign busy_out      = (state_ff != psw_pkg::PSW_IDLE);
  assign sclk_out      = gen_clk_ff;
  assign sclk_oe_out   = clock_direction_select_in & ~floating;
  assign data_out      = data_ff;
  assign data_oe_out   = ~floating;
  assign strobe_out    = strobe_ff;
  assign strobe_oe_out = ~floating;
endmodule
`default_nettype wire

// File: psw_regs.svh
// constants for the power switch serial port
`ifndef PSW_REGS_SVH
`define PSW_REGS_SVH
// Notes on behaviour
// - each data bit is held stable so it is caught on a rising shift clock.
// - the shift clock pin is an input after reset and is driven only when clock_direction_select is set.
// - a driven shift clock is the bus clock divided by 36.
// - whoever makes the shift clock keeps it at or below 2 MHz.
// - the data line is an output carrying the power control bits one at a time.
// - the strobe tells the switch that the shifted word is complete and valid.
// - with the strobe pin pulled down, the eeprom clock and data move to pins four and one.
// - all logic is timed from and samples on the rising bus clock edge.
// - reset without suspend floats all outputs, clears all registers and stops all function.
// - after reset release everything starts at its default.
// - reset with suspend floats all outputs but keeps register contents; here the shift clock divider keeps counting.
`define PSW_CLK_DIV        36
`define PSW_HALF_DIV       18
`define PSW_CLK_HZ         50000000
`define PSW_SCLK_MAX_HZ    2000000
`define PSW_FRAME_BITS     8
`define PSW_CNT_W          5
`define PSW_BIT_W          4
`endif

// File: psw_sw.sv
// behavioural power switch model with its pin pulls
`timescale 1ns/1ps
`default_nettype none
module psw_sw (
  // pins from the port
  input wire logic clk_in, sclk_out, sclk_oe_out, data_out, data_oe_out,
  input wire logic strobe_out, strobe_oe_out,
  // strap pull-down and free clock enable
  input wire logic pull_dn_in, run_in,
  // pins back to the port
  output logic sclk_in, strobe_in
);
  logic       ext_clk = 1'b0;
  logic       last_st = 1'b0;
  logic [7:0] sh      = 8'h00;
  logic [7:0] got[$];
  int         div     = 0;
  // own clock of 30 bus cycles, stands low unless asked
  always @(posedge clk_in) begin
    div <= (div == 14) ? 0 : div + 1;
    if (div == 14) ext_clk <= run_in & ~ext_clk;
    if (strobe_oe_out) last_st <= strobe_out;
  end
  // a floating strobe shows the pull, else the inverse of its last level
  assign sclk_in = sclk_oe_out ? sclk_out : ext_clk;
  assign strobe_in = strobe_oe_out ? strobe_out :
                     (pull_dn_in ? 1'b0 : ~last_st);
  // bits caught on rising clock, word taken at strobe
  always @(posedge sclk_in) sh <= {sh[6:0], data_oe_out ? data_out : ~sh[0]};
  always @(posedge strobe_in) if (strobe_oe_out) got.push_back(sh);
endmodule
`default_nettype wire

// File: tb.sv
// testbench for the power switch serial port
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk_in = 1'b0, rst_n_in = 1'b0, bus_reset_n_in = 1'b1;
  logic       suspend_in = 1'b0, clock_direction_select_in = 1'b0;
  logic       word_valid_in = 1'b0, pull_dn_in = 1'b1, run_in = 1'b0;
  logic [7:0] word_data_in = 8'h00;
  logic       word_ready_out, busy_out, sclk_out, sclk_oe_out, data_out;
  logic       data_oe_out, strobe_out, strobe_oe_out;
  logic       eeprom_on_alt_pins_out, eeprom_clock_pin_sel_out;
  logic       eeprom_data_pin_sel_out;
  wire        sclk_in, strobe_in;
  int         bad_count = 0, checked = 0;
  psw_port psw_port_i (.*);
  psw_sw   psw_sw_i (.*);
  always #10 clk_in = ~clk_in;
  task automatic chk(input string what, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    if (bad_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // hold the word until the edge that takes it
  task automatic push(input logic [7:0] w);
    int n;
    n = 0;
    @(posedge clk_in);
    word_valid_in <= 1'b1;
    word_data_in <= w;
    do @(negedge clk_in); while (word_ready_out !== 1'b1 && ++n < 3000);
    @(posedge clk_in);
    word_valid_in <= 1'b0;
  endtask
  task automatic wait_got(input int k);
    int n;
    n = 0;
    while (psw_sw_i.got.size() < k && n++ < 3000) @(negedge clk_in);
  endtask
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy_out !== lvl && n++ < 3000) @(negedge clk_in);
  endtask
  // one word on the divided bus clock
  task automatic t_send_int;
    @(posedge clk_in);
    clock_direction_select_in <= 1'b1;
    push(8'ha5);
    wait_got(1);
    chk("sclk_oe", sclk_oe_out, 8'h01);
    chk("word", psw_sw_i.got[0], 8'ha5);
    wait_busy(1'b0);
    psw_sw_i.got.delete();
  endtask
  // three words on the switch's clock fill the buffer
  task automatic t_burst;
    @(posedge clk_in);
    clock_direction_select_in <= 1'b0;
    run_in <= 1'b1;
    push(8'h3c);
    push(8'hc3);
    push(8'h01);
    @(negedge clk_in);
    chk("ready", word_ready_out, 8'h00);
    wait_got(3);
    chk("w0", psw_sw_i.got[0], 8'h3c);
    chk("w1", psw_sw_i.got[1], 8'hc3);
    chk("w2", psw_sw_i.got[2], 8'h01);
    wait_busy(1'b0);
    run_in <= 1'b0;
    psw_sw_i.got.delete();
  endtask
  // bus reset mid-frame; suspend decides whether state survives
  task automatic t_reset(input logic susp, pd);
    @(posedge clk_in);
    clock_direction_select_in <= 1'b1;
    pull_dn_in <= pd;
    push(8'hff);
    wait_busy(1'b1);
    repeat (90) @(posedge clk_in);
    suspend_in <= susp;
    bus_reset_n_in <= 1'b0;
    repeat (6) @(negedge clk_in);
    chk("data_oe", data_oe_out, 8'h00);
    chk("strobe_oe", strobe_oe_out, 8'h00);
    chk("busy", busy_out, {7'h00, susp});
    @(posedge clk_in);
    bus_reset_n_in <= 1'b1;
    suspend_in <= 1'b0;
    wait_busy(1'b0);
    repeat (120) @(negedge clk_in);
    chk("idle", busy_out, 8'h00);
    chk("got", 8'(psw_sw_i.got.size()), {7'h00, susp});
    if (!susp) chk("strap", eeprom_on_alt_pins_out, {7'h00, pd});
    if (!susp) chk("scl", eeprom_clock_pin_sel_out, {7'h00, pd});
    if (!susp) chk("sda", eeprom_data_pin_sel_out, {7'h00, pd});
    psw_sw_i.got.delete();
  endtask
  initial begin
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(negedge clk_in);
    chk("sclk_oe", sclk_oe_out, 8'h00);
    chk("data_oe", data_oe_out, 8'h01);
    chk("strap0", eeprom_on_alt_pins_out, 8'h01);
    t_send_int;
    t_burst;
    t_reset(1'b0, 1'b1);
    t_reset(1'b0, 1'b0);
    t_reset(1'b1, 1'b0);
    close_out;
  end
  // hang guard, well past the expected run
  initial begin
    repeat (60000) @(posedge clk_in);
    bad_count++;
    close_out;
  end
endmodule
`default_nettype wire
